// ===== dv/pcs_opdrv.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_opdrv (
  input wire logic aclk,
  output logic pc_advance,
  output logic call_instr,
  output logic jump_instr,
  output logic int_vector_take,
  output logic return_instr,
  output logic return_literal_instr,
  output logic return_from_int_instr,
  output logic [10:0] addr_field,
  output logic ind_sel,
  output logic acc_rd,
  output logic acc_wr,
  output logic [8:0] dir_addr
);
  logic [6:0] ops;
  assign {return_from_int_instr, return_literal_instr, return_instr, int_vector_take, jump_instr, call_instr,
    pc_advance} = ops;
  initial begin
    ops = 7'h00;
    addr_field = 11'h000;
    {ind_sel, acc_rd, acc_wr} = 3'h0;
    dir_addr = 9'h000;
  end
  // one-cycle pulses only, as the decoder issues them
  task automatic op(input int k, input logic [10:0] a);
    @(posedge aclk);
    ops <= 7'(7'h01 << k);
    addr_field <= a;
    @(posedge aclk);
    ops <= 7'h00;
    addr_field <= ~a;
    #1;
  endtask : op
  task automatic ind(input logic s, input logic r, input logic w, input logic [8:0] d);
    @(posedge aclk);
    {ind_sel, acc_rd, acc_wr} <= {s, r, w};
    dir_addr <= d;
    @(posedge aclk);
    {ind_sel, acc_rd, acc_wr} <= 3'h0;
    dir_addr <= ~d;
    #1;
  endtask : ind
endmodule : pcs_opdrv
`default_nettype wire

// ===== dv/program_counter_stack_indirect_bench.sv
`timescale 1ns/1ns
`default_nettype none
module program_counter_stack_indirect_bench;
  import pcs_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic pc_advance, call_instr, jump_instr, int_vector_take, return_instr, return_literal_instr;
  logic return_from_int_instr, ind_sel, acc_rd, acc_wr, ind_rd_zero, ind_wr_block;
  logic [10:0] addr_field;
  logic [8:0] dir_addr, eff_addr;
  logic [12:0] pc;
  int fail_count, tests_run, cyc;
  pcs_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_advance, .call_instr,
    .jump_instr, .int_vector_take, .return_instr, .return_literal_instr, .return_from_int_instr, .addr_field,
    .ind_sel, .acc_rd, .acc_wr, .dir_addr, .pc, .eff_addr, .ind_rd_zero, .ind_wr_block);
  pcs_opdrv u_mdl (.aclk, .pc_advance, .call_instr, .jump_instr, .int_vector_take, .return_instr,
    .return_literal_instr, .return_from_int_instr, .addr_field, .ind_sel, .acc_rd, .acc_wr, .dir_addr);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    // generous ceiling, the whole run needs well under a thousand cycles
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk(pc, 32'h0);
    wr(OFF_PC_HIGH_LATCH, 32'h1F);
    wr(OFF_PC_LOW_BYTE, 32'hA5);
    #1 chk(pc, 32'h1FA5);
    rd(OFF_PC_LOW_BYTE);
    chk(rdv, 32'hA5);
    u_mdl.op(1, 11'h123);
    chk(pc, 32'h0923);
    u_mdl.op(4, 11'h000);
    chk(pc, 32'h1FA5);
    rd(OFF_PC_HIGH_LATCH);
    chk(rdv, 32'h1F);
    // computed jump past the byte boundary: bit 8 of the sum must not carry
    wr(OFF_PC_LOW_BYTE, 32'h1A4);
    #1 chk(pc, 32'h1FA4);
    wr(OFF_PC_HIGH_LATCH, 32'h10);
    u_mdl.op(2, 11'h7FF);
    chk(pc, 32'h07FF);
    u_mdl.op(0, 11'h000);
    chk(pc, 32'h0800);
    u_mdl.op(3, 11'h000);
    chk(pc, 32'(INT_VECTOR));
    u_mdl.op(6, 11'h000);
    chk(pc, 32'h0800);
    // nine calls: the ninth push lands on the first slot
    for (int i = 1; i <= 9; i++) u_mdl.op(1, 11'(i * 16));
    for (int i = 8; i >= 1; i--) begin
      u_mdl.op(4 + i % 3, 11'h000);
      chk(pc, 32'(i * 16));
    end
    u_mdl.op(5, 11'h000);
    chk(pc, 32'h0080);
    wr(OFF_STATUS, 32'h80);
    rd(OFF_STATUS);
    chk(rdv, 32'h80);
    wr(OFF_INDIRECT_POINTER, 32'h3C);
    u_mdl.ind(1'b1, 1'b1, 1'b0, 9'h000);
    chk(eff_addr, 32'h13C);
    chk(ind_rd_zero, 32'h0);
    wr(OFF_STATUS, 32'h00);
    wr(OFF_INDIRECT_POINTER, 32'h00);
    // low lane strobe off: the write is answered but lands nowhere
    s_axi_wstrb <= 4'hE;
    wr(OFF_INDIRECT_POINTER, 32'h3C);
    s_axi_wstrb <= 4'hF;
    chk(resp, 32'(RESP_OKAY));
    u_mdl.ind(1'b1, 1'b1, 1'b0, 9'h000);
    chk(ind_rd_zero, 32'h1);
    u_mdl.ind(1'b1, 1'b0, 1'b1, 9'h000);
    chk(ind_wr_block, 32'h1);
    u_mdl.ind(1'b0, 1'b1, 1'b1, 9'h055);
    chk(eff_addr, 32'h055);
    chk({ind_rd_zero, ind_wr_block}, 32'h0);
    wr(8'h10, 32'hFF);
    chk(resp, 32'(RESP_SLVERR));
    rd(8'h10);
    chk(rdv, 32'h0);
    chk(resp, 32'(RESP_SLVERR));
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1 chk(pc, 32'h0);
    give_verdict();
  end
endmodule : program_counter_stack_indirect_bench
`default_nettype wire

// ===== rtl/pcs_core.sv
// Contract
// - program counter is 13 bits and addresses program memory
// - low counter byte is readable and writable by software
// - counter bits 12..8 are never directly accessed, only loaded from the latch
// - every reset clears the whole counter
// - low byte write loads the byte plus latch bits 4..0 above it
// - call or jump loads 11 address bits plus latch bit 3, bit 12 cleared
// - return stack of 8 x 13 bits with hidden pointer
// - call or interrupt vectoring pushes the counter
// - any return pops the stack into the counter
// - push and pop leave the high latch unchanged
// - stack is circular, ninth push overwrites the first
// - no overflow or underflow flag exists
// - full 13-bit counter is pushed so returns restore the page
// - latch bit 4 is ignored for paging
// - indirect location redirects to the address in the pointer
// - indirect read with pointer zero returns 00h
// - indirect write to itself stores nothing
// - indirect address is bank bit over the 8-bit pointer
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pcs_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcs_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pcs_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pc_advance,
  input wire logic call_instr,
  input wire logic jump_instr,
  input wire logic int_vector_take,
  input wire logic return_instr,
  input wire logic return_literal_instr,
  input wire logic return_from_int_instr,
  input wire logic [pcs_pkg::PAGE_ADDR_W-1:0] addr_field,
  input wire logic ind_sel,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [pcs_pkg::FILE_ADDR_W-1:0] dir_addr,
  output logic [pcs_pkg::PC_W-1:0] pc,
  output logic [pcs_pkg::FILE_ADDR_W-1:0] eff_addr,
  output logic ind_rd_zero,
  output logic ind_wr_block
);
  import pcs_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [LATCH_W-1:0] high_latch;
    logic [LOW_W-1:0] pointer;
    logic bank;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [FILE_ADDR_W-1:0] eff_addr;
    logic ind_rd_zero;
    logic ind_wr_block;
  } pcs_core_st_t;

  pcs_core_st_t s;
  pcs_core_st_t next_s;

  logic sw_low_wr;
  logic [LOW_W-1:0] sw_low_byte;
  logic stk_push;
  logic stk_pop;
  logic ret_go;
  logic [PC_W-1:0] stk_top;
  logic wr_commit;

  function automatic logic reg_known(input logic [AXI_ADDR_W-1:0] a);
    reg_known = (a == OFF_PC_LOW_BYTE) || (a == OFF_PC_HIGH_LATCH) ||
                (a == OFF_INDIRECT_POINTER) || (a == OFF_STATUS);
  endfunction : reg_known

  function automatic logic [PC_W-1:0] page_target(input logic [LATCH_W-1:0] lat,
                                                   input logic [PAGE_ADDR_W-1:0] a);
    // latch bit 4 dropped: a call or jump reaches only two pages of program memory
    page_target = {1'b0, lat[PAGE_BIT], a};
  endfunction : page_target

  assign ret_go = return_instr || return_literal_instr || return_from_int_instr;

  pcs_stack u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(s.pc),
    .top(stk_top)
  );

  always_comb begin
    next_s = s;
    sw_low_wr = 1'b0;
    sw_low_byte = s.w_data[LOW_W-1:0];
    stk_push = 1'b0;
    stk_pop = 1'b0;
    wr_commit = 1'b0;

    // write channel: address and data taken independently
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (next_s.aw_held && next_s.w_held && !next_s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      wr_commit = 1'b1;
      next_s.bresp = reg_known(next_s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      sw_low_byte = next_s.w_data[LOW_W-1:0];
      // only the low lane carries register bits
      if (next_s.w_strb[0]) begin
        if (next_s.aw_addr == OFF_PC_LOW_BYTE) begin
          sw_low_wr = 1'b1;
        end else if (next_s.aw_addr == OFF_PC_HIGH_LATCH) begin
          next_s.high_latch = next_s.w_data[LATCH_W-1:0];
        end else if (next_s.aw_addr == OFF_INDIRECT_POINTER) begin
          next_s.pointer = next_s.w_data[LOW_W-1:0];
        end
      end
      if (next_s.w_strb[0] && next_s.aw_addr == OFF_STATUS) begin
        next_s.bank = next_s.w_data[BANK_BIT_POS];
      end
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;

    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = '0;
      // high counter bits have no read path at all
      if (s_axi_araddr == OFF_PC_LOW_BYTE) begin
        next_s.rdata[LOW_W-1:0] = s.pc[LOW_W-1:0];
      end else if (s_axi_araddr == OFF_PC_HIGH_LATCH) begin
        next_s.rdata[LATCH_W-1:0] = s.high_latch;
      end else if (s_axi_araddr == OFF_INDIRECT_POINTER) begin
        next_s.rdata[LOW_W-1:0] = s.pointer;
      end else if (s_axi_araddr == OFF_STATUS) begin
        next_s.rdata[BANK_BIT_POS] = s.bank;
      end
    end
    next_s.arready = !next_s.rvalid;

    // counter sequencing; a software load wins over the core that cycle
    if (sw_low_wr) begin
      // no carry path: the high part always comes from the latch
      next_s.pc = {s.high_latch, sw_low_byte};
    end else if (int_vector_take) begin
      stk_push = 1'b1;
      next_s.pc = INT_VECTOR;
    end else if (call_instr) begin
      stk_push = 1'b1;
      next_s.pc = page_target(s.high_latch, addr_field);
    end else if (jump_instr) begin
      next_s.pc = page_target(s.high_latch, addr_field);
    end else if (ret_go) begin
      stk_pop = 1'b1;
      next_s.pc = stk_top;
    end else if (pc_advance) begin
      next_s.pc = s.pc + PC_STEP;
    end

    // indirect operand redirection
    next_s.eff_addr = ind_sel ? {s.bank, s.pointer} : dir_addr;
    next_s.ind_rd_zero = ind_sel && acc_rd && (s.pointer == IND_SELF_PTR);
    next_s.ind_wr_block = ind_sel && acc_wr && (s.pointer == IND_SELF_PTR);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pc = s.pc;
  assign eff_addr = s.eff_addr;
  // data path zeroes the read word when this is high
  assign ind_rd_zero = s.ind_rd_zero;
  assign ind_wr_block = s.ind_wr_block;

  // helpers for checks
  logic call_go;
  logic core_idle;
  logic latch_wr;
  logic int_go;
  logic branch_go;
  logic adv_go;
  logic ret_only;
  logic rd_take;
  logic ind_self;
  assign call_go = call_instr && !int_vector_take && !sw_low_wr;
  assign core_idle = !sw_low_wr && !int_vector_take && !call_instr && !jump_instr && !ret_go && !pc_advance;
  // a software write is the only legal way to change the latch
  assign latch_wr = wr_commit && next_s.w_strb[0] && next_s.aw_addr == OFF_PC_HIGH_LATCH;
  assign int_go = int_vector_take && !sw_low_wr;
  assign branch_go = (call_instr || jump_instr) && !int_vector_take && !sw_low_wr;
  assign adv_go = pc_advance && !sw_low_wr && !int_vector_take && !call_instr && !jump_instr && !ret_go;
  assign ret_only = ret_go && !sw_low_wr && !int_vector_take && !call_instr && !jump_instr;
  assign rd_take = s.arready && s_axi_arvalid;
  assign ind_self = ind_sel && s.pointer == IND_SELF_PTR;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence call_then_return_s;
    call_go ##1 core_idle ##1 (ret_go && !sw_low_wr && !int_vector_take && !call_instr && !jump_instr);
  endsequence

  sequence low_write_s;
    sw_low_wr;
  endsequence

  sequence int_then_return_s;
    int_go ##1 core_idle ##1 ret_only;
  endsequence

  reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> pc == '0)
    else $error("counter not cleared by reset");
  low_load_a: assert property (low_write_s |=> pc == {$past(s.high_latch), $past(sw_low_byte)})
    else $error("low byte write did not load counter");
  page_load_a: assert property (jump_instr && !call_instr && !int_vector_take && !sw_low_wr
      |=> pc == {1'b0, $past(s.high_latch[PAGE_BIT]), $past(addr_field)})
    else $error("jump target wrong");
  call_return_a: assert property (call_then_return_s |=> pc == $past(pc, 3))
    else $error("return did not restore pushed counter");
  latch_steady_a: assert property ((stk_push || stk_pop) && !latch_wr |=> $stable(s.high_latch))
    else $error("stack action changed high latch");
  latch_only_sw_a: assert property (!latch_wr |=> $stable(s.high_latch))
    else $error("latch changed outside a write");
  ind_addr_a: assert property (ind_sel |=> eff_addr == {$past(s.bank), $past(s.pointer)})
    else $error("indirect address wrong");
  ind_zero_a: assert property (ind_sel && acc_rd && s.pointer == IND_SELF_PTR |=> ind_rd_zero)
    else $error("self indirect read not zeroed");
  ind_block_a: assert property (ind_wr_block |-> $past(ind_sel) && $past(acc_wr) && $past(s.pointer) == IND_SELF_PTR)
    else $error("write blocked without self pointer");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  adv_step_a: assert property (adv_go |=> pc == $past(pc) + PC_STEP)
    else $error("counter did not step");
  pc_hold_a: assert property (core_idle |=> $stable(pc))
    else $error("counter moved without a load");
  high_part_a: assert property (low_write_s
      |=> pc[PC_W-1:LOW_W] == $past(s.high_latch))
    else $error("high counter bits not from latch");
  int_vector_a: assert property (int_go |=> pc == INT_VECTOR)
    else $error("interrupt vector not loaded");
  call_page_a: assert property (call_go
      |=> pc == {1'b0, $past(s.high_latch[PAGE_BIT]), $past(addr_field)})
    else $error("call target wrong");
  page_top_a: assert property (branch_go |=> pc[PC_W-1] == 1'b0)
    else $error("latch bit 4 leaked into a branch");
  int_return_a: assert property (int_then_return_s |=> pc == $past(pc, 3))
    else $error("return after interrupt lost the counter");
  call_push_a: assert property (call_go |=> stk_top == $past(pc))
    else $error("call did not push the counter");
  ret_pop_a: assert property (ret_only |=> pc == $past(stk_top))
    else $error("return did not load the stack top");
  low_read_a: assert property (rd_take && s_axi_araddr == OFF_PC_LOW_BYTE
      |=> s_axi_rdata[LOW_W-1:0] == $past(pc[LOW_W-1:0]) && s_axi_rdata[AXI_DATA_W-1:LOW_W] == '0)
    else $error("low byte read wrong");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  wr_answer_a: assert property (wr_commit |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered next cycle");
  unmapped_rd_a: assert property (rd_take && !reg_known(s_axi_araddr)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  ind_dir_a: assert property (!ind_sel |=> eff_addr == $past(dir_addr))
    else $error("direct address not passed");
  ind_quiet_a: assert property (!ind_self |=> !ind_rd_zero && !ind_wr_block)
    else $error("indirect guard raised without self pointer");
  ind_wr_self_a: assert property (ind_self && acc_wr |=> ind_wr_block)
    else $error("self indirect write not blocked");
  latch_load_a: assert property (latch_wr
      |=> s.high_latch == $past(next_s.w_data[LATCH_W-1:0]))
    else $error("latch write lost");
  rd_ready_a: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
    else $error("read channel not reopened");
  bresp_map_a: assert property (wr_commit && !reg_known(next_s.aw_addr)
      |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  wr_ready_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  ptr_load_a: assert property (wr_commit && next_s.w_strb[0] && next_s.aw_addr == OFF_INDIRECT_POINTER
      |=> s.pointer == $past(next_s.w_data[LOW_W-1:0]))
    else $error("pointer write lost");
  strb_guard_a: assert property (wr_commit && !next_s.w_strb[0] |=> $stable(s.pointer) && $stable(s.bank))
    else $error("write without low lane changed state");
endmodule : pcs_core
`default_nettype wire

// ===== rtl/pcs_pkg.sv
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int PAGE_ADDR_W = 11;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  localparam int FILE_ADDR_W = 9;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int PAGE_BIT = 3;
  localparam int BANK_BIT_POS = 7;

  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // interrupt vector value is an arbitrary default
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [LOW_W-1:0] IND_SELF_PTR = 8'h00;
  localparam logic [LOW_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [STK_PTR_W-1:0] STK_STEP = 3'h1;

  localparam logic [AXI_ADDR_W-1:0] OFF_PC_LOW_BYTE = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_PC_HIGH_LATCH = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_INDIRECT_POINTER = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 8'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcs_pkg

// ===== rtl/pcs_stack.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_stack (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [pcs_pkg::PC_W-1:0] push_data,
  output logic [pcs_pkg::PC_W-1:0] top
);
  import pcs_pkg::*;

  typedef struct packed {
    logic [STK_DEPTH-1:0][PC_W-1:0] slot;
    logic [STK_PTR_W-1:0] ptr;
  } pcs_stack_st_t;

  pcs_stack_st_t s;
  pcs_stack_st_t next_s;

  // pointer is internal only, no port reads or writes it
  always_comb begin
    next_s = s;
    top = s.slot[s.ptr - STK_STEP];
    if (push) begin
      next_s.slot[s.ptr] = push_data;
      next_s.ptr = s.ptr + STK_STEP;
    end else if (pop) begin
      // empty pop wraps and hands back a stale slot, no error
      next_s.ptr = s.ptr - STK_STEP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ptr_wrap_a: assert property (push && s.ptr == 3'h7 |=> s.ptr == 3'h0)
    else $error("stack pointer did not wrap on push");
  pop_wrap_a: assert property (pop && !push && s.ptr == 3'h0 |=> s.ptr == 3'h7)
    else $error("stack pointer did not wrap on pop");
endmodule : pcs_stack
`default_nettype wire
